// ### src/uwtd_pkg.sv
/*
  Shared constants and types of the serial transceiver with its transmit
  DMA register bank. Assumes Avalon-MM word access, 8-bit registers.
*/
package uwtd_pkg;
  // Register index; byte address is four times the index
  localparam logic [13:0] IDX_HOLD     = 14'h0000;
  localparam logic [13:0] IDX_FMT      = 14'h0003;
  localparam logic [13:0] IDX_MODE     = 14'h0004;
  localparam logic [13:0] IDX_STATUS   = 14'h0005;
  localparam logic [13:0] IDX_CMD      = 14'h0006;
  localparam logic [13:0] IDX_BAUD_LO  = 14'h0007;
  localparam logic [13:0] IDX_BAUD_HI  = 14'h0008;
  localparam logic [13:0] IDX_RTO      = 14'h0009;
  localparam logic [13:0] IDX_TTG      = 14'h000a;
  localparam logic [13:0] IDX_TAD_LO   = 14'h2000;
  localparam logic [13:0] IDX_DMA_EN   = 14'h2001;
  localparam logic [13:0] IDX_LEN_LO   = 14'h2003;
  localparam logic [13:0] IDX_LEN_HI   = 14'h2004;
  localparam logic [13:0] IDX_SENT_LO  = 14'h2005;
  localparam logic [13:0] IDX_SENT_HI  = 14'h2006;
  localparam logic [7:0]  REG_RESET    = 8'h00;

  // Command register bit positions, then the DMA enable register bit
  localparam int CMD_RX_ON   = 7;
  localparam int CMD_CLR_ERR = 6;
  localparam int CMD_TX_ON   = 5;
  localparam int CMD_RESTART = 4;
  localparam int CMD_TX_RST  = 3;
  localparam int CMD_RX_RST  = 2;
  localparam int CMD_BRK_END = 1;
  localparam int CMD_BRK_GO  = 0;
  localparam int DMA_ON_BIT  = 7;

  // Oversampling counts, in ticks of the 16x rate
  localparam logic [5:0] TICKS_BIT    = 6'h10;
  localparam logic [5:0] TICKS_STOP15 = 6'h18;
  localparam logic [5:0] TICKS_STOP2  = 6'h20;
  localparam logic [3:0] RX_MID       = 4'h7;
  localparam logic [3:0] RX_LAST      = 4'hf;

  // Channel modes
  localparam logic [1:0] CH_NORMAL = 2'h0;
  localparam logic [1:0] CH_ECHO   = 2'h1;
  localparam logic [1:0] CH_LOCAL  = 2'h2;
  localparam logic [1:0] CH_REMOTE = 2'h3;

  // Frame format register layout
  typedef struct packed {
    logic [1:0] char_len;
    logic [1:0] stop_len;
    logic [2:0] parity;
    logic       rsvd;
  } uwtd_fmt_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h3,
    TX_PAR   = 3'h2,
    TX_STOP  = 3'h6,
    TX_GUARD = 3'h7
  } uwtd_tx_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h3,
    RX_PAR   = 3'h2,
    RX_STOP  = 3'h6
  } uwtd_rx_t;
endpackage

// ### src/uwtd_top.sv
/*
  Serial transceiver with transmit DMA register bank, one clock.
  Assumes an Avalon-MM master, a shared memory answering reads with
  mem_ack, and a remote serial device on rxd and txd.
*/
// The Avalon-MM register port was chosen for this implementation.
module uwtd_top (
  input  wire logic        clock,       // 200 MHz system clock
  input  wire logic        sys_rst,     // Synchronous reset
  input  wire logic [15:0] address,     // Byte address
  input  wire logic        read,        // Read request
  input  wire logic        write,       // Write request
  input  wire logic [31:0] writedata,   // Write data
  input  wire logic [3:0]  byteenable,  // Lane 0 carries registers
  output logic      [31:0] readdata,    // Read data
  output logic             waitrequest, // Stall until answer
  input  wire logic        rxd,         // Serial line in
  output logic             txd,         // Serial line out
  output logic             mem_rd,      // Shared memory read request
  output logic      [11:0] mem_addr,    // Shared memory byte address
  input  wire logic        mem_ack,     // Read data valid
  input  wire logic [7:0]  mem_data     // Read data
);

  // Parity bit for a character under a parity mode
  function automatic logic par_bit(input logic [2:0] m, input logic [7:0] d);
    unique case (m[1:0])
      2'h0: par_bit = ^d;
      2'h1: par_bit = ~^d;
      2'h2: par_bit = 1'b0;
      2'h3: par_bit = 1'b1;
    endcase
  endfunction

  // Keep only the bits of the programmed length
  function automatic logic [7:0] mask_char(input logic [1:0] l, input logic [7:0] d);
    mask_char = d & (8'hff >> (2'h3 - l));
  endfunction

  // Register state
  uwtd_pkg::uwtd_fmt_t fmt;
  logic [1:0]  chan;
  logic        rx_on;
  logic        tx_on;
  logic [7:0]  baud_lo;
  logic [7:0]  baud_hi;
  logic [7:0]  rto;
  logic [7:0]  ttg;
  logic        dma_on;
  logic [11:0] tad;
  logic [10:0] plen;
  logic [10:0] sent;
  logic        dma_act;
  logic        done_ok;
  logic        done_early;

  // Bus decode
  logic [7:0]  rd_mux;
  logic [7:0]  status;
  wire         req     = read | write;
  wire         wr_acc  = write & ~waitrequest & byteenable[0];
  wire         rd_acc  = read & ~waitrequest;
  wire  [13:0] idx     = address[15:2];
  wire  [7:0]  wd      = writedata[7:0];
  wire         w_hold  = wr_acc & (idx == uwtd_pkg::IDX_HOLD);
  wire         w_cmd   = wr_acc & (idx == uwtd_pkg::IDX_CMD);
  wire         w_dma   = wr_acc & (idx == uwtd_pkg::IDX_DMA_EN);
  wire         r_hold  = rd_acc & (idx == uwtd_pkg::IDX_HOLD);
  wire         r_dsta  = rd_acc & (idx == uwtd_pkg::IDX_SENT_HI);

  // One-cycle command strobes
  // clear faults
  wire clr_err  = w_cmd & wd[uwtd_pkg::CMD_CLR_ERR];
  wire restart  = w_cmd & wd[uwtd_pkg::CMD_RESTART];
  wire tx_rst   = sys_rst | (w_cmd & wd[uwtd_pkg::CMD_TX_RST]);
  wire rx_rst   = sys_rst | (w_cmd & wd[uwtd_pkg::CMD_RX_RST]);
  wire brk_go   = w_cmd & wd[uwtd_pkg::CMD_BRK_GO];
  wire brk_end  = w_cmd & wd[uwtd_pkg::CMD_BRK_END];

  // Answer one cycle after the request appears; every access costs two edges
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      waitrequest <= 1'b1;
    else
      waitrequest <= ~(req & waitrequest);
  end

  // Read data captured while the answer is prepared
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      readdata <= 32'h0;
    else if (req & waitrequest)
      readdata <= {24'h0, rd_mux};
  end

  // Plain configuration registers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      fmt     <= uwtd_pkg::uwtd_fmt_t'(uwtd_pkg::REG_RESET);
      chan    <= uwtd_pkg::REG_RESET[1:0];
      rx_on   <= 1'b0;
      tx_on   <= 1'b0;
      baud_lo <= uwtd_pkg::REG_RESET;
      baud_hi <= uwtd_pkg::REG_RESET;
      rto     <= uwtd_pkg::REG_RESET;
      ttg     <= uwtd_pkg::REG_RESET;
      plen    <= 11'h0;
    end
    else if (wr_acc)
    begin
      unique case (idx)
        uwtd_pkg::IDX_FMT:     fmt     <= uwtd_pkg::uwtd_fmt_t'(wd);
        uwtd_pkg::IDX_MODE:    chan    <= wd[7:6];
        uwtd_pkg::IDX_CMD:
        begin
          rx_on <= wd[uwtd_pkg::CMD_RX_ON];
          tx_on <= wd[uwtd_pkg::CMD_TX_ON];
        end
        uwtd_pkg::IDX_BAUD_LO: baud_lo <= wd;
        uwtd_pkg::IDX_BAUD_HI: baud_hi <= wd;
        uwtd_pkg::IDX_RTO:     rto     <= wd;
        uwtd_pkg::IDX_TTG:     ttg     <= wd;
        uwtd_pkg::IDX_LEN_LO:  plen[7:0]  <= wd;
        uwtd_pkg::IDX_LEN_HI:  plen[10:8] <= wd[2:0];
        default:               ;
      endcase
    end
  end

  // Baud generator: 16x tick, a zero divisor halts the line
  logic [15:0] bcnt;
  logic [3:0]  bsub;
  wire  [15:0] divisor = {baud_hi, baud_lo};
  wire         tick16  = (divisor != 16'h0) & (bcnt == divisor - 16'h1);
  wire         bit_tick = tick16 & (bsub == uwtd_pkg::RX_LAST);

  always_ff @(posedge clock)
  begin
    if (sys_rst | ~(|divisor))
    begin
      bcnt <= 16'h0;
      bsub <= 4'h0;
    end
    else
    begin
      bcnt <= tick16 ? 16'h0 : bcnt + 16'h1;
      if (tick16)
        bsub <= bsub + 4'h1;
    end
  end

  // Transmitter
  uwtd_pkg::uwtd_tx_t tx_st;
  logic [7:0] tx_holding_ready;
  logic       thr_full;
  logic [7:0] tsr;
  logic       tx_par;
  logic [2:0] tx_bits;
  logic [5:0] tx_sub;
  logic [7:0] tx_guard;
  logic       brk;
  logic       tx_line;
  logic [5:0] stop_ticks;
  wire        has_par  = ~fmt.parity[2];
  // last data bit index is four plus the code
  wire  [2:0] last_bit = 3'h4 + {1'b0, fmt.char_len};
  wire        dma_load = mem_rd & mem_ack;
  wire        cpu_load = w_hold & ~thr_full & ~mem_rd;
  wire        tx_adv   = tick16 & tx_on;
  wire  [5:0] tx_lim   = (tx_st == uwtd_pkg::TX_STOP) ? stop_ticks : uwtd_pkg::TICKS_BIT;
  wire        tx_end   = tx_adv & (tx_sub == tx_lim - 6'h1);

  always_comb
  begin
    unique case (fmt.stop_len)
      2'h0:    stop_ticks = uwtd_pkg::TICKS_BIT;
      2'h1:    stop_ticks = uwtd_pkg::TICKS_STOP15;
      default: stop_ticks = uwtd_pkg::TICKS_STOP2;
    endcase
  end

  // Line level of the running character
  always_comb
  begin
    unique case (tx_st)
      uwtd_pkg::TX_START: tx_line = 1'b0;
      uwtd_pkg::TX_DATA:  tx_line = tsr[0];
      uwtd_pkg::TX_PAR:   tx_line = tx_par;
      default:            tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (tx_rst)
    begin
      tx_st    <= uwtd_pkg::TX_IDLE;
      tx_holding_ready      <= 8'h0;
      thr_full <= 1'b0;
      tsr      <= 8'h0;
      tx_par   <= 1'b0;
      tx_bits  <= 3'h0;
      tx_sub   <= 6'h0;
      tx_guard <= 8'h0;
    end
    else
    begin
      if (dma_load | cpu_load)
      begin
        tx_holding_ready      <= dma_load ? mem_data : wd;
        thr_full <= 1'b1;
      end
      if (tx_adv & (tx_st != uwtd_pkg::TX_IDLE))
        tx_sub <= tx_end ? 6'h0 : tx_sub + 6'h1;
      unique case (tx_st)
        uwtd_pkg::TX_IDLE:
          // holding moves to shift register only when enabled
          if (tx_on & thr_full & ~brk)
          begin
            tsr      <= mask_char(fmt.char_len, tx_holding_ready);
            tx_par   <= par_bit(fmt.parity, mask_char(fmt.char_len, tx_holding_ready));
            thr_full <= 1'b0;
            tx_sub   <= 6'h0;
            tx_st    <= uwtd_pkg::TX_START;
          end
        uwtd_pkg::TX_START:
          if (tx_end)
          begin
            tx_bits <= 3'h0;
            tx_st   <= uwtd_pkg::TX_DATA;
          end
        uwtd_pkg::TX_DATA:
          if (tx_end)
          begin
            tsr     <= tsr >> 1;
            tx_bits <= tx_bits + 3'h1;
            if (tx_bits == last_bit)
              tx_st <= has_par ? uwtd_pkg::TX_PAR : uwtd_pkg::TX_STOP;
          end
        uwtd_pkg::TX_PAR:
          if (tx_end)
            tx_st <= uwtd_pkg::TX_STOP;
        uwtd_pkg::TX_STOP:
          // guard gap after the stop bits
          if (tx_end)
          begin
            tx_guard <= 8'h1;
            tx_st    <= (ttg != 8'h0) ? uwtd_pkg::TX_GUARD : uwtd_pkg::TX_IDLE;
          end
        uwtd_pkg::TX_GUARD:
          if (tx_end)
          begin
            tx_guard <= tx_guard + 8'h1;
            if (tx_guard >= ttg)
              tx_st <= uwtd_pkg::TX_IDLE;
          end
      endcase
    end
  end

  // break held until the stop command; stop wins if both written
  always_ff @(posedge clock)
  begin
    if (tx_rst)
      brk <= 1'b0;
    else if (brk_end)
      brk <= 1'b0;
    else if (brk_go)
      brk <= 1'b1;
  end

  // Channel routing
  wire tx_wire = brk ? 1'b0 : tx_line;
  // receiver input per channel mode; remote loopback idles it
  wire rx_in   = (chan == uwtd_pkg::CH_LOCAL)  ? tx_wire :
                 (chan == uwtd_pkg::CH_REMOTE) ? 1'b1 : rxd;

  // echo modes return the line, local loopback keeps it idle
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      txd <= 1'b1;
    else
    begin
      unique case (chan)
        uwtd_pkg::CH_NORMAL: txd <= tx_wire;
        uwtd_pkg::CH_LOCAL:  txd <= 1'b1;
        default:             txd <= rxd;
      endcase
    end
  end

  // Receiver
  uwtd_pkg::uwtd_rx_t rx_st;
  logic [7:0] rx_sr;
  logic [7:0] rx_holding_full;
  logic [3:0] rx_sub;
  logic [2:0] rx_bits;
  logic       rx_pbit;
  logic       rx_armed;
  logic       rx_full;
  logic       pe;
  logic       fe;
  logic       oe;
  logic       rbrk;
  logic       rtof;
  logic [7:0] tmo;
  wire        rx_adv  = tick16 & rx_on;
  wire        rx_samp = rx_adv & (rx_sub == uwtd_pkg::RX_LAST);
  wire  [7:0] rx_data = rx_sr >> (2'h3 - fmt.char_len);
  wire        rx_done = rx_samp & (rx_st == uwtd_pkg::RX_STOP);
  wire        bad_stop = ~rx_in;
  // all-zero character with low stop, and low parity bit if enabled, is a break
  wire        is_brk  = bad_stop & (rx_data == 8'h0) & ~(has_par & rx_pbit);
  wire        bad_par = has_par & (rx_pbit != par_bit(fmt.parity, rx_data));

  always_ff @(posedge clock)
  begin
    if (rx_rst)
    begin
      rx_st    <= uwtd_pkg::RX_IDLE;
      rx_sr    <= 8'h0;
      rx_sub   <= 4'h0;
      rx_bits  <= 3'h0;
      rx_pbit  <= 1'b0;
      rx_armed <= 1'b0;
    end
    else if (rx_adv)
    begin
      rx_sub <= rx_sub + 4'h1;
      unique case (rx_st)
        uwtd_pkg::RX_IDLE:
        begin
          // A line stuck low after a break must rise before a new start
          rx_armed <= rx_in;
          rx_sub   <= 4'h0;
          if (rx_armed & ~rx_in)
            rx_st <= uwtd_pkg::RX_START;
        end
        uwtd_pkg::RX_START:
          if (rx_sub == uwtd_pkg::RX_MID)
          begin
            rx_sub  <= 4'h0;
            rx_bits <= 3'h0;
            rx_st   <= rx_in ? uwtd_pkg::RX_IDLE : uwtd_pkg::RX_DATA;
          end
        uwtd_pkg::RX_DATA:
          if (rx_samp)
          begin
            rx_sr   <= {rx_in, rx_sr[7:1]};
            rx_bits <= rx_bits + 3'h1;
            if (rx_bits == last_bit)
              rx_st <= has_par ? uwtd_pkg::RX_PAR : uwtd_pkg::RX_STOP;
          end
        uwtd_pkg::RX_PAR:
          if (rx_samp)
          begin
            rx_pbit <= rx_in;
            rx_st   <= uwtd_pkg::RX_STOP;
          end
        uwtd_pkg::RX_STOP:
          if (rx_samp)
          begin
            rx_armed <= 1'b0;
            rx_st    <= uwtd_pkg::RX_IDLE;
          end
      endcase
    end
  end

  // Receive flags; a new event beats a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (rx_rst)
    begin
      rx_holding_full     <= 8'h0;
      rx_full <= 1'b0;
      pe      <= 1'b0;
      fe      <= 1'b0;
      oe      <= 1'b0;
      rbrk    <= 1'b0;
    end
    else
    begin
      if (rx_done)
        rx_holding_full <= rx_data;
      rx_full <= rx_done | (rx_full & ~r_hold);
      oe      <= (rx_done & rx_full & ~r_hold) | (oe & ~clr_err);
      pe      <= (rx_done & bad_par) | (pe & ~clr_err);
      fe      <= (rx_done & bad_stop) | (fe & ~clr_err);
      rbrk    <= (rx_done & is_brk) | rbrk;
    end
  end

  // Receive timeout in bit periods, armed by restart or a character
  wire tmo_run = rx_on & (rto != 8'h0) & (rx_st == uwtd_pkg::RX_IDLE) & (tmo != 8'h0);
  always_ff @(posedge clock)
  begin
    if (rx_rst)
    begin
      tmo  <= 8'h0;
      rtof <= 1'b0;
    end
    else
    begin
      if (restart | rx_done)
        tmo <= rto;
      // count bit periods, zero register never arms
      else if (tmo_run & bit_tick)
        tmo <= tmo - 8'h1;
      // flag at the end of the period
      rtof <= (tmo_run & bit_tick & (tmo == 8'h1)) | (rtof & ~restart);
    end
  end

  // Transmit DMA engine
  // enable bit and high address bits; count and flags
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      dma_on     <= 1'b0;
      dma_act    <= 1'b0;
      tad        <= 12'h0;
      sent       <= 11'h0;
      mem_rd     <= 1'b0;
      mem_addr   <= 12'h0;
      done_ok    <= 1'b0;
      done_early <= 1'b0;
    end
    else
    begin
      done_ok    <= done_ok & ~(r_dsta & readdata[4]);
      done_early <= done_early & ~(r_dsta & readdata[3]);
      if (wr_acc & (idx == uwtd_pkg::IDX_TAD_LO))
        tad[7:0] <= wd;
      if (w_dma)
      begin
        dma_on    <= wd[uwtd_pkg::DMA_ON_BIT];
        tad[11:8] <= wd[3:0];
        if (wd[uwtd_pkg::DMA_ON_BIT] & ~dma_act)
        begin
          dma_act  <= 1'b1;
          sent     <= 11'h0;
          mem_addr <= {wd[3:0], tad[7:0]};
        end
        else if (~wd[uwtd_pkg::DMA_ON_BIT] & dma_act)
        begin
          // Stopped by software before the length was reached
          dma_act    <= 1'b0;
          mem_rd     <= 1'b0;
          done_early <= 1'b1;
        end
      end
      else if (dma_act)
      begin
        if (dma_load)
        begin
          mem_rd   <= 1'b0;
          sent     <= sent + 11'h1;
          mem_addr <= mem_addr + 12'h1;
        end
        else if (sent == plen)
        begin
          dma_act <= 1'b0;
          dma_on  <= 1'b0;
          done_ok <= 1'b1;
        end
        else if (~mem_rd & ~thr_full & ~w_hold)
          mem_rd <= 1'b1;
      end
    end
  end

  // Status word and read mux
  // both stages idle
  assign status = {~thr_full & (tx_st == uwtd_pkg::TX_IDLE), rtof, pe, fe, oe, rbrk, ~thr_full, rx_full};

  always_comb
  begin
    unique case (idx)
      uwtd_pkg::IDX_HOLD:    rd_mux = rx_holding_full;
      uwtd_pkg::IDX_FMT:     rd_mux = fmt;
      uwtd_pkg::IDX_MODE:    rd_mux = {chan, 6'h0};
      uwtd_pkg::IDX_STATUS:  rd_mux = status;
      uwtd_pkg::IDX_CMD:     rd_mux = {rx_on, 1'b0, tx_on, 5'h0};
      uwtd_pkg::IDX_BAUD_LO: rd_mux = baud_lo;
      uwtd_pkg::IDX_BAUD_HI: rd_mux = baud_hi;
      uwtd_pkg::IDX_RTO:     rd_mux = rto;
      uwtd_pkg::IDX_TTG:     rd_mux = ttg;
      uwtd_pkg::IDX_TAD_LO:  rd_mux = tad[7:0];
      uwtd_pkg::IDX_DMA_EN:  rd_mux = {dma_on, 3'h0, tad[11:8]};
      uwtd_pkg::IDX_LEN_LO:  rd_mux = plen[7:0];
      uwtd_pkg::IDX_LEN_HI:  rd_mux = {5'h0, plen[10:8]};
      uwtd_pkg::IDX_SENT_LO: rd_mux = sent[7:0];
      uwtd_pkg::IDX_SENT_HI: rd_mux = {3'h0, done_ok, done_early, sent[10:8]};
      default:               rd_mux = 8'h0;
    endcase
  end

endmodule // uwtd_top

// ### dv/uwtd_asserts.sv
/*
  Port checker for uwtd_top.
  Assumes divisor of at least 1 whenever txd moves.
*/
module uwtd_asserts (
  input wire logic        clock,       // System clock
  input wire logic        sys_rst,     // Sync reset
  input wire logic        read,        // Read request
  input wire logic        write,       // Write request
  input wire logic [31:0] readdata,    // Read data
  input wire logic        waitrequest, // Stall
  input wire logic        txd,         // Serial out
  input wire logic        mem_rd,      // Fetch request
  input wire logic [11:0] mem_addr,    // Fetch address
  input wire logic        mem_ack      // Fetch answer
);
  timeunit 1ns;
  timeprecision 100ps;
  // One domain, so one clock and reset for all
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest stuck high");
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_rdata_stands: assert property (waitrequest ##1 waitrequest |-> $stable(readdata))
    else $error("readdata moved between accesses");
  a_fetch_hold: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
    else $error("fetch dropped early");
  a_fetch_release: assert property (mem_rd && mem_ack |=> !mem_rd)
    else $error("fetch held after answer");
  a_reset_idle: assert property ($fell(sys_rst) |-> txd && waitrequest && !mem_rd && mem_addr == 12'h0)
    else $error("outputs not idle after reset");
  // Any low period is low on its first eight clocks and on its sixteenth
  a_low_width: assert property ($fell(txd) |-> !txd [*8] ##8 !txd)
    else $error("line low shorter than a bit");
endmodule // uwtd_asserts

bind uwtd_top uwtd_asserts u_chk (.clock, .sys_rst, .read, .write, .readdata, .waitrequest,
  .txd, .mem_rd, .mem_addr, .mem_ack);

// ### dv/uwtd_remote.sv
/*
  Remote serial device on the far side of the line.
  Assumes divisor 1, so 16 clocks a bit.
*/
module uwtd_remote (
  input wire logic clock, // System clock
  input wire logic txd,   // Line from the block
  output logic     rxd    // Line to the block
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BITCLK = 16; // Clocks per bit
  initial rxd = 1'b1;

  // Eight bits LSB first; stop level chosen to force faults
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BITCLK) @(posedge clock);
    end
    rxd <= 1'b1;
  endtask

  // Mid-bit samples of nb bits plus one trailing bit
  task automatic recv(input int nb, output logic [8:0] v);
    v = '0;
    @(negedge txd);
    repeat (BITCLK / 2) @(posedge clock);
    for (int i = 0; i <= nb; i++)
    begin
      repeat (BITCLK) @(posedge clock);
      v[i] = txd;
    end
  endtask
endmodule // uwtd_remote

// ### dv/uart_with_tx_dma_regs_test.sv
/*
  Self-checking bench for uwtd_top.
  Assumes a bus answer one cycle after each request.
*/
module uart_with_tx_dma_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0, sys_rst = 1'b1, read = 1'b0, write = 1'b0;
  logic [15:0] address = 16'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic        waitrequest, rxd, txd, mem_rd, mem_ack = 1'b0;
  logic [11:0] mem_addr;
  logic [7:0]  mem_data = 8'h0, rv;
  logic [8:0]  v, ev;
  logic [11:0] aq[$];
  int          fail_count = 0, n_tests = 0, cyc = 0, wt = 0, nb, p;
  logic [13:0] ti[9] = '{14'h3, 14'h4, 14'h7, 14'h9, 14'h2000, 14'h2001, 14'h2003, 14'h2005, 14'hb};
  logic [7:0]  tw[9] = '{8'hc8, 8'hc0, 8'h01, 8'h02, 8'h10, 8'h0f, 8'h02, 8'haa, 8'h55};
  logic [7:0]  te[9] = '{8'hc8, 8'hc0, 8'h01, 8'h02, 8'h10, 8'h0f, 8'h02, 8'h00, 8'h00};

  uwtd_top DUT (.clock, .sys_rst, .address, .read, .write, .writedata, .byteenable(4'h1),
    .readdata, .waitrequest, .rxd, .txd, .mem_rd, .mem_addr, .mem_ack, .mem_data);
  uwtd_remote PEER (.clock, .txd, .rxd);

  initial forever #2.5 clock = ~clock;

  // Memory answers after four cycles; idle data toggles
  always @(posedge clock)
  begin
    mem_ack <= 1'b0;
    mem_data <= ~mem_data;
    wt <= (mem_rd && !mem_ack) ? wt + 1 : 0;
    if (mem_rd && !mem_ack && wt == 3)
    begin
      mem_ack <= 1'b1;
      mem_data <= mem_addr[7:0] ^ 8'h5a;
      aq.push_back(mem_addr);
    end
  end

  // Watchdog
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [13:0] ix, input logic [7:0] d);
    address <= {ix, 2'b00};
    write <= wr;
    read <= !wr;
    writedata <= {24'h0, d};
    do @(posedge clock); while (waitrequest !== 1'b0);
    rv = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdchk(input string nm, input logic [13:0] ix, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, ix, 8'h0);
    chk(nm, rv & m, e);
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 9; i++)
    begin
      rdchk("reset", ti[i], 8'hff, 8'h00);
      bus(1'b1, ti[i], tw[i]);
      rdchk("readback", ti[i], 8'hff, te[i]);
    end
    bus(1'b1, 14'h4, 8'h00);
    bus(1'b1, 14'h6, 8'ha0);
    // Every length code, then parity codes 0 to 3
    for (int c = 0; c < 8; c++)
    begin
      nb = c < 4 ? 5 + c : 8;
      p = c - 4;
      bus(1'b1, 14'h3, c < 4 ? {c[1:0], 6'b001000} : {5'h18, p[1:0], 1'b0});
      ev = c < 4 ? ((9'h1 << nb) | (9'hb6 & ((9'h1 << nb) - 9'h1)))
                 : {p == 0 ? ^8'hb6 : p == 1 ? ~^8'hb6 : p[0], 8'hb6};
      fork
        bus(1'b1, 14'h0, 8'hb6);
        PEER.recv(nb, v);
      join
      chk("frame", v, ev);
      repeat (40) @(posedge clock);
    end
    rdchk("txempty", 14'h5, 8'h82, 8'h82);
    bus(1'b1, 14'h3, 8'hc8);
    PEER.send(8'h3c, 1'b1);
    rdchk("rxfull", 14'h5, 8'h01, 8'h01);
    PEER.send(8'h5e, 1'b0);
    rdchk("faults", 14'h5, 8'h18, 8'h18);
    bus(1'b1, 14'h6, 8'he0);
    rdchk("cleared", 14'h5, 8'h38, 8'h00);
    bus(1'b0, 14'h0, 8'h00);
    rdchk("rxempty", 14'h5, 8'h01, 8'h00);
    bus(1'b1, 14'h4, 8'h40);
    bus(1'b1, 14'h4, 8'h80);
    bus(1'b1, 14'h0, 8'h69);
    repeat (200) @(posedge clock);
    rdchk("loopback", 14'h0, 8'hff, 8'h69);
    bus(1'b1, 14'h4, 8'h00);
    bus(1'b1, 14'h6, 8'hb0);
    rdchk("tmo_early", 14'h5, 8'h40, 8'h00);
    repeat (40) @(posedge clock);
    rdchk("tmo_late", 14'h5, 8'h40, 8'h40);
    bus(1'b1, 14'h6, 8'ha1);
    repeat (20) @(posedge clock);
    chk("break_on", txd, 1'b0);
    bus(1'b1, 14'h6, 8'ha2);
    repeat (4) @(posedge clock);
    chk("break_off", txd, 1'b1);
    // All-zero character with a low stop bit reads as a break
    PEER.send(8'h00, 1'b0);
    rdchk("rx_break", 14'h5, 8'h04, 8'h04);
    bus(1'b1, 14'h6, 8'ha4);
    rdchk("rx_reset", 14'h5, 8'h1d, 8'h00);
    // Two-byte fetch from 0xf10 leaves on the line
    fork
      bus(1'b1, 14'h2001, 8'h8f);
      begin
        PEER.recv(8, v);
        chk("dma0", v, 9'h14a);
        PEER.recv(8, v);
        chk("dma1", v, 9'h14b);
      end
    join
    chk("addr0", aq.pop_front(), 12'hf10);
    chk("addr1", aq.pop_front(), 12'hf11);
    repeat (40) @(posedge clock);
    rdchk("sent", 14'h2005, 8'hff, 8'h02);
    rdchk("done", 14'h2006, 8'hff, 8'h10);
    rdchk("rdclr", 14'h2006, 8'hff, 8'h00);
    rdchk("dma_off", 14'h2001, 8'h80, 8'h00);
    close_out();
  end
endmodule // uart_with_tx_dma_regs_test
